// ### hw/table_access_pkg.sv
package table_access_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PTR_W = 21;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int HOLD_SEL_W = 3;
    localparam int HOLD_N = 8;
    // ------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------
    localparam logic [11:0] TABLE_PREFIX = 12'h000;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h3;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_POSTDEC = 2'h2;
    localparam logic [1:0] MODE_PREINC = 2'h3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] HOLD_RESET = 8'hFF;
    localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
endpackage

// ### hw/table_read_write_exec.sv
// How it works
// - Opcode zero prefix, then 10, then two mode bits selects table read.
// - Post modes read old pointer then step; pre-increment steps then reads.
// - Table read loads addressed program byte into latch; flags untouched.
// - Pointer is a 21-bit byte address over two megabytes.
// - Pointer bit zero picks low (0) or high (1) byte of word.
// - Read takes two cycles: decode, then memory read and latch write.
// - Zero prefix, 11, mode bits selects table write; same pointer modes.
// - Write copies latch to holding register chosen by pointer low three bits.
// - Holding registers stage flash data; writes never touch program memory.
// - Write takes two cycles; second reads latch and writes holding register.
`timescale 1ns/1ps
`default_nettype none
module table_read_write_exec
    import table_access_pkg::*;
#(
    parameter int PTR_WIDTH = PTR_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic instrValid,
    input wire logic [INSTR_W-1:0] instrWord,
    input wire logic [INSTR_W-1:0] progWord,
    input wire logic ptrLoad,
    input wire logic [PTR_W-1:0] ptrLoadValue,
    input wire logic latchLoad,
    input wire logic [DATA_W-1:0] latchLoadValue,
    output logic busy,
    output logic [PTR_W-1:0] tablePointer,
    output logic [DATA_W-1:0] tableLatch,
    output logic [PTR_W-2:0] progWordAddr,
    output logic progRead,
    output logic [HOLD_N*DATA_W-1:0] holdingRegs,
    output logic holdWriteStrobe,
    output logic statusWrite
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        READ_EXEC = 3'b010,
        WRITE_EXEC = 3'b100
    } phase_e;

    function automatic logic isTableOp(input logic [INSTR_W-1:0] w, input logic [1:0] op);
        isTableOp = (w[15:4] == TABLE_PREFIX) && (w[3:2] == op);
    endfunction

    function automatic logic [PTR_W-1:0] stepPtr(input logic [PTR_W-1:0] p,
                                                 input logic [1:0] m);
        unique case (m)
            MODE_POSTINC, MODE_PREINC: stepPtr = p + PTR_ONE;
            MODE_POSTDEC: stepPtr = p - PTR_ONE;
            MODE_NONE: stepPtr = p;
        endcase
    endfunction

    phase_e phase_q;
    logic [1:0] mode_q;
    logic [PTR_W-1:0] accessPtr;
    logic [PTR_W-1:0] issuePtr;
    logic startRead;
    logic startWrite;

    assign startRead = (phase_q == IDLE) && instrValid && isTableOp(instrWord, OP_READ);
    assign startWrite = (phase_q == IDLE) && instrValid && isTableOp(instrWord, OP_WRITE);
    // Pre-increment is applied in the decode cycle, so the pointer already moved
    assign accessPtr = tablePointer;
    // Read address follows a pre-increment taken on this same edge
    assign issuePtr = (startRead && instrWord[1:0] == MODE_PREINC) ?
        stepPtr(tablePointer, MODE_PREINC) : tablePointer;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= IDLE;
            mode_q <= MODE_NONE;
        end else begin
            unique case (phase_q)
                IDLE: begin
                    mode_q <= instrWord[1:0];
                    if (startRead) begin
                        phase_q <= READ_EXEC;
                    end else if (startWrite) begin
                        phase_q <= WRITE_EXEC;
                    end
                end
                READ_EXEC, WRITE_EXEC: begin
                    phase_q <= IDLE;
                end
                default: phase_q <= IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= startRead || startWrite;
        end
    end

    // ------------------------------------------------------------
    // Pointer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tablePointer <= PTR_RESET;
        end else if ((startRead || startWrite) && instrWord[1:0] == MODE_PREINC) begin
            tablePointer <= stepPtr(tablePointer, MODE_PREINC);
        end else if (phase_q != IDLE && mode_q != MODE_PREINC) begin
            tablePointer <= stepPtr(tablePointer, mode_q);
        end else if (phase_q == IDLE && ptrLoad && !(startRead || startWrite)) begin
            // Load yields to a starting op, so the op sees the pointer it decoded
            tablePointer <= ptrLoadValue;
        end
    end

    // ------------------------------------------------------------
    // Program memory access
    // ------------------------------------------------------------
    // Address and strobe are registered, so the word returns in the execute cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            progWordAddr <= '0;
            progRead <= 1'b0;
        end else begin
            progRead <= startRead;
            progWordAddr <= issuePtr[PTR_W-1:1];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tableLatch <= LATCH_RESET;
        end else if (phase_q == READ_EXEC) begin
            tableLatch <= accessPtr[0] ? progWord[15:8] : progWord[7:0];
        end else if (latchLoad) begin
            tableLatch <= latchLoadValue;
        end
    end

    // ------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------
    // Only staging; programming of the array is started elsewhere
    genvar gi;
    generate
        for (gi = 0; gi < HOLD_N; gi++) begin : g_hold
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    holdingRegs[gi*DATA_W +: DATA_W] <= HOLD_RESET;
                end else if (phase_q == WRITE_EXEC &&
                             accessPtr[HOLD_SEL_W-1:0] == HOLD_SEL_W'(gi)) begin
                    holdingRegs[gi*DATA_W +: DATA_W] <= tableLatch;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            holdWriteStrobe <= 1'b0;
            statusWrite <= 1'b0;
        end else begin
            holdWriteStrobe <= (phase_q == WRITE_EXEC);
            statusWrite <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_read_two_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        startRead |=> (phase_q == READ_EXEC) ##1 (phase_q == IDLE))
        else $error("read not two cycles");
    a_write_two_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        startWrite |=> (phase_q == WRITE_EXEC) ##1 holdWriteStrobe)
        else $error("write not two cycles");
    a_preinc_ptr: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (startRead && instrWord[1:0] == MODE_PREINC && !ptrLoad) |=>
        tablePointer == $past(tablePointer) + PTR_ONE)
        else $error("pre-increment wrong");
    a_postinc_ptr: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (startRead && instrWord[1:0] == MODE_POSTINC) |=> ##1
        tablePointer == $past(tablePointer, 2) + PTR_ONE)
        else $error("post-increment wrong");
    a_postdec_ptr: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (startWrite && instrWord[1:0] == MODE_POSTDEC) |=> ##1
        tablePointer == $past(tablePointer, 2) - PTR_ONE)
        else $error("post-decrement wrong");
    a_latch_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase_q == READ_EXEC) |=>
        tableLatch == ($past(accessPtr[0]) ? $past(progWord[15:8]) : $past(progWord[7:0])))
        else $error("latch byte wrong");
    a_read_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase_q == READ_EXEC) |-> progRead && progWordAddr == accessPtr[PTR_W-1:1])
        else $error("read address wrong");
    a_hold_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase_q == WRITE_EXEC) |=>
        holdingRegs[$past(accessPtr[HOLD_SEL_W-1:0])*DATA_W +: DATA_W] == $past(tableLatch))
        else $error("holding register wrong");
    a_no_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !statusWrite)
        else $error("status written");
    a_preinc_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (startWrite && instrWord[1:0] == MODE_PREINC) |=>
        tablePointer == $past(tablePointer) + PTR_ONE)
        else $error("write pre-increment wrong");
    a_postdec_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (startRead && instrWord[1:0] == MODE_POSTDEC) |=> ##1
        tablePointer == $past(tablePointer, 2) - PTR_ONE)
        else $error("read post-decrement wrong");
    a_mode_none: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ((startRead || startWrite) && instrWord[1:0] == MODE_NONE) |=> ##1
        tablePointer == $past(tablePointer, 2))
        else $error("pointer moved without mode");
    a_busy_exec: assert property (@(posedge ref_clk) disable iff (!rst_b)
        busy |-> (phase_q != IDLE))
        else $error("busy outside execute");
    a_read_strobe: assert property (@(posedge ref_clk) disable iff (!rst_b)
        progRead |-> (phase_q == READ_EXEC))
        else $error("memory read outside table read");
endmodule // table_read_write_exec
`default_nettype wire

// ### sim/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
    import table_access_pkg::*;
(
    input wire logic progRead,
    input wire logic [PTR_W-2:0] progWordAddr,
    output logic [INSTR_W-1:0] progWord
);
    // -------------------------------------------
    // Word contents
    // -------------------------------------------
    // Inverted outside a read, so a stale sample never looks right
    always_comb begin
        progWord = {progWordAddr[7:0] ^ 8'h3C, progWordAddr[7:0]};
        if (!progRead) begin
            progWord = ~progWord;
        end
    end
endmodule // prog_mem_model
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import table_access_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, instrValid = 1'b0, ptrLoad = 1'b0, latchLoad = 1'b0;
    logic [INSTR_W-1:0] instrWord = 16'h0000;
    logic [INSTR_W-1:0] progWord;
    logic [PTR_W-1:0] ptrLoadValue = 21'h000000;
    logic [DATA_W-1:0] latchLoadValue = 8'h00;
    logic busy, progRead, holdWriteStrobe, statusWrite;
    logic [PTR_W-1:0] tablePointer;
    logic [DATA_W-1:0] tableLatch;
    logic [PTR_W-2:0] progWordAddr;
    logic [HOLD_N*DATA_W-1:0] holdingRegs;
    int bad_count = 0, total_checks = 0;
    logic [PTR_W-1:0] starts [4] = '{21'h00A356, 21'h1FFFFF, 21'h000000, 21'h01A357};
    always #12.5 ref_clk = ~ref_clk;
    table_read_write_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .instrValid(instrValid),
        .instrWord(instrWord), .progWord(progWord), .ptrLoad(ptrLoad),
        .ptrLoadValue(ptrLoadValue), .latchLoad(latchLoad), .latchLoadValue(latchLoadValue),
        .busy(busy), .tablePointer(tablePointer), .tableLatch(tableLatch),
        .progWordAddr(progWordAddr), .progRead(progRead), .holdingRegs(holdingRegs),
        .holdWriteStrobe(holdWriteStrobe), .statusWrite(statusWrite));
    prog_mem_model mem (.progRead(progRead), .progWordAddr(progWordAddr), .progWord(progWord));
    // -------------------------------------------
    // Shared tasks
    // -------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic load(input logic [PTR_W-1:0] p, input logic [DATA_W-1:0] d);
        @(negedge ref_clk);
        ptrLoad = 1'b1;
        ptrLoadValue = p;
        latchLoad = 1'b1;
        latchLoadValue = d;
        @(negedge ref_clk);
        ptrLoad = 1'b0;
        latchLoad = 1'b0;
    endtask
    // Issue, then look once in the execute cycle and once after completion
    task automatic exec(input logic [INSTR_W-1:0] w, input logic bz, input logic rd);
        instrValid = 1'b1;
        instrWord = w;
        @(negedge ref_clk);
        instrValid = 1'b0;
        chk(busy, bz, "busy");
        chk(progRead, rd, "progRead");
        @(negedge ref_clk);
        chk(statusWrite, 1'b0, "status");
        chk(busy, 1'b0, "busy end");
    endtask
    // -------------------------------------------
    // Scenarios
    // -------------------------------------------
    task automatic test_read();
        logic [PTR_W-1:0] p, e, n;
        for (int m = 0; m < 4; m++) begin
            p = starts[m];
            e = (m == 3) ? p + PTR_ONE : p;
            n = (m == 0) ? p : ((m == 2) ? p - PTR_ONE : p + PTR_ONE);
            load(p, 8'h00);
            exec({TABLE_PREFIX, OP_READ, 2'(m)}, 1'b1, 1'b1);
            chk(tableLatch, e[0] ? e[8:1] ^ 8'h3C : e[8:1], "latch");
            chk(tablePointer, n, "pointer");
        end
        $display("test_read done");
    endtask
    task automatic test_write();
        logic [PTR_W-1:0] p, e, n;
        for (int m = 0; m < 4; m++) begin
            p = starts[m];
            e = (m == 3) ? p + PTR_ONE : p;
            n = (m == 0) ? p : ((m == 2) ? p - PTR_ONE : p + PTR_ONE);
            load(p, 8'h50 + 8'(m));
            exec({TABLE_PREFIX, OP_WRITE, 2'(m)}, 1'b1, 1'b0);
            chk(holdingRegs[e[2:0]*8 +: 8], 8'h50 + 8'(m), "holding");
            chk(holdWriteStrobe, 1'b1, "strobe");
            chk(tablePointer, n, "pointer");
            chk(tableLatch, 8'h50 + 8'(m), "latch kept");
        end
        $display("test_write done");
    endtask
    task automatic test_reset();
        chk(holdingRegs, {HOLD_N{HOLD_RESET}}, "holding reset");
        chk(tablePointer, PTR_RESET, "pointer reset");
        chk(tableLatch, LATCH_RESET, "latch reset");
        $display("test_reset done");
    endtask
    // Held request: busy cycle refuses it, the next idle edge takes the next one
    task automatic test_order();
        load(21'h00A356, 8'h55);
        instrValid = 1'b1;
        instrWord = {TABLE_PREFIX, OP_WRITE, MODE_POSTINC};
        repeat (2) @(negedge ref_clk);
        instrWord = {TABLE_PREFIX, OP_WRITE, MODE_PREINC};
        @(negedge ref_clk);
        chk(busy, 1'b1, "second taken");
        instrWord = {TABLE_PREFIX, OP_READ, MODE_NONE};
        @(negedge ref_clk);
        instrValid = 1'b0;
        chk(busy, 1'b0, "read refused");
        chk(holdingRegs[6*DATA_W +: DATA_W], 8'h55, "first hold");
        chk(holdingRegs[0 +: DATA_W], 8'h55, "second hold");
        chk(tablePointer, 21'h00A358, "pointer order");
        chk(tableLatch, 8'h55, "latch untouched");
        $display("test_order done");
    endtask
    task automatic test_ignore();
        load(21'h000123, 8'h77);
        exec(16'h0010, 1'b0, 1'b0);
        chk(tablePointer, 21'h000123, "pointer kept");
        $display("test_ignore done");
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        test_reset();
        test_read();
        test_write();
        test_ignore();
        test_order();
        wrap_up();
    end
    // Whole run needs 54 cycles
    initial begin
        #(25 * 2000);
        bad_count++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
